// [hw/quad_wiper_command_control.sv]
// two-wire slave and quick-command engine for four wiper registers
`timescale 1ns/1ns
`default_nettype none
module quad_wiper_command_control #(
  parameter int unsigned RestoreCycles = quad_wiper_pkg::RESTORE_CYC,
  parameter int unsigned StoreCycles   = quad_wiper_pkg::STORE_CYC
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            scl,
  input  wire logic            sdaIn,
  input  wire logic            writeProtectN,
  input  wire logic            addrSelectHi,
  input  wire logic            addrSelectLo,
  output wire logic            sdaOut,
  output wire logic            sdaOutEn,
  output wire logic [3:0][7:0] wiperPos,
  output wire logic            chargePump,
  output wire logic            nvBusy
);
  import quad_wiper_pkg::*;

  localparam logic [OP_W-1:0] RestoreLast = OP_W'(RestoreCycles - 1);
  localparam logic [OP_W-1:0] StoreLast   = OP_W'(StoreCycles - 1);

  function automatic logic isAllCmd(input logic [3:0] c);
    return c == CMD_HALVE_ALL || c == CMD_DEC_ALL || c == CMD_DOUBLE_ALL || c == CMD_INC_ALL;
  endfunction

  function automatic logic isStepCmd(input logic [3:0] c);
    return c == CMD_HALVE_ONE || c == CMD_DEC_ONE || c == CMD_DOUBLE_ONE
        || c == CMD_INC_ONE || isAllCmd(c);
  endfunction

  function automatic logic [7:0] stepOp(input logic [3:0] c, input logic [7:0] v);
    logic [7:0] r;
    r = v;
    unique case (c)
      CMD_HALVE_ONE, CMD_HALVE_ALL: r = v >> 1;
      CMD_DEC_ONE, CMD_DEC_ALL: r = (v == ZERO_SCALE) ? ZERO_SCALE : v - 8'h01;
      // zero doubles to one, so nine doublings reach full scale
      CMD_DOUBLE_ONE, CMD_DOUBLE_ALL:
        r = (v == ZERO_SCALE) ? 8'h01 : (v[7] ? FULL_SCALE : {v[6:0], 1'b0});
      CMD_INC_ONE, CMD_INC_ALL: r = (v == FULL_SCALE) ? FULL_SCALE : v + 8'h01;
      default: r = v;
    endcase
    return r;
  endfunction

  // pin synchronisers: scl, sda, write protect, two select pins
  logic [4:0] syncA_q;
  logic [4:0] syncB_q;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  always_ff @(posedge clk_sys) begin
    syncA_q   <= {scl, sdaIn, writeProtectN, addrSelectHi, addrSelectLo};
    syncB_q   <= syncA_q;
    sclPrev_q <= syncB_q[4];
    sdaPrev_q <= syncB_q[3];
  end

  wire logic       sclB     = syncB_q[4];
  wire logic       sdaB     = syncB_q[3];
  // the pad pull-down makes an open pin read low, i.e. protected
  wire logic       wpOn     = !syncB_q[2];
  wire logic [1:0] pinsAddr = syncB_q[1:0];
  wire logic       sclRise  = sclB && !sclPrev_q;
  wire logic       sclFall  = !sclB && sclPrev_q;
  wire logic       startC   = sclB && sclPrev_q && sdaPrev_q && !sdaB;
  wire logic       stopC    = sclB && sclPrev_q && !sdaPrev_q && sdaB;

  linkState_t       st_q;
  logic [3:0]       cnt_q;
  logic [7:0]       sh_q;
  logic             oe_q;
  logic             hostAck_q;
  logic [7:0]       txByte_q;
  logic [1:0]       rdPtr_q;
  logic             cmdMode_q;
  logic             regNv_q;
  logic [4:0]       regAddr_q;
  logic [3:0][7:0]  wiper_q;
  logic [3:0][7:0]  nv_q;
  logic             busy_q;
  logic             storing_q;
  logic             opAll_q;
  logic [1:0]       opCh_q;
  logic [7:0]       storeVal_q;
  logic [OP_W-1:0]  opCnt_q;

  // prefix plus select pins; no answer while busy
  wire logic addrHit = sh_q[7:1] == {ADDR_PREFIX, pinsAddr} && !busy_q;
  wire logic addrAck = sclFall && st_q == S_ADDR && cnt_q == 4'd8;
  wire logic instrAck = sclFall && st_q == S_INSTR && cnt_q == 4'd8;
  wire logic dataAck  = sclFall && st_q == S_DATA && cnt_q == 4'd8;
  // quick command decode: top bit, four code bits, channel bits
  wire logic [3:0] cmdCode = sh_q[CMD_MSB:CMD_LSB];
  wire logic       quick   = instrAck && sh_q[INSTR_QUICK] && !busy_q;
  wire logic       allCh   = isAllCmd(cmdCode);
  wire logic [1:0] qCh     = sh_q[1:0];
  wire logic       qChOk   = !sh_q[CH_MSB];
  wire logic [7:0] qWiper  = wiper_q[qCh];
  // protection gates every modifying path but not the restores
  wire logic stepGo = quick && !wpOn && isStepCmd(cmdCode) && (allCh || qChOk);
  // single restore; reset of all channels
  wire logic restoreGo = quick && ((cmdCode == CMD_RESTORE && qChOk) || cmdCode == CMD_RESET_ALL);
  wire logic storeCmdGo = quick && !wpOn && cmdCode == CMD_STORE && qChOk;
  wire logic regGo      = dataAck && !cmdMode_q && !busy_q && !wpOn && regAddr_q[4:2] == 3'h0;
  wire logic nvWrGo     = regGo && regNv_q;
  wire logic wiperWrGo  = regGo && !regNv_q;
  wire logic storeGo    = storeCmdGo || nvWrGo;
  wire logic [1:0] tgtCh = storeCmdGo ? qCh : regAddr_q[1:0];
  wire logic opDone = busy_q && opCnt_q == (storing_q ? StoreLast : RestoreLast);

  // serial link state machine, sampled on clk_sys
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q      <= S_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      oe_q      <= 1'b0;
      hostAck_q <= 1'b0;
      txByte_q  <= 8'h00;
      rdPtr_q   <= 2'h0;
      cmdMode_q <= 1'b0;
      regNv_q   <= 1'b0;
      regAddr_q <= 5'h00;
    end else if (startC) begin
      st_q  <= S_ADDR;
      cnt_q <= 4'h0;
      oe_q  <= 1'b0;
    end else if (stopC) begin
      st_q <= S_IDLE;
      oe_q <= 1'b0;
    end else if (sclRise && st_q != S_IDLE && cnt_q <= 4'd8) begin
      if (cnt_q < 4'd8) begin
        sh_q <= {sh_q[6:0], sdaB};
      end else begin
        hostAck_q <= !sdaB;
      end
      cnt_q <= cnt_q + 4'h1;
    end else if (sclFall && cnt_q == 4'd8) begin
      unique case (st_q)
        S_ADDR: oe_q <= addrHit;
        S_INSTR, S_DATA: oe_q <= 1'b1;
        default: oe_q <= 1'b0;
      endcase
      if (st_q == S_INSTR) begin
        cmdMode_q <= sh_q[INSTR_QUICK];
        regNv_q   <= sh_q[INSTR_NV];
        regAddr_q <= sh_q[4:0];
      end
    end else if (sclFall && cnt_q == 4'd9) begin
      cnt_q <= 4'h0;
      oe_q  <= 1'b0;
      unique case (st_q)
        S_ADDR: begin
          if (!oe_q) begin
            st_q <= S_IGNORE;
          end else if (sh_q[0]) begin
            st_q     <= S_READ;
            txByte_q <= wiper_q[0];
            rdPtr_q  <= 2'h1;
            oe_q     <= !wiper_q[0][7];
          end else begin
            st_q <= S_INSTR;
          end
        end
        S_INSTR: st_q <= S_DATA;
        S_READ: begin
          if (hostAck_q) begin
            txByte_q <= wiper_q[rdPtr_q];
            rdPtr_q  <= rdPtr_q + 2'h1;
            oe_q     <= !wiper_q[rdPtr_q][7];
          end else begin
            st_q <= S_IGNORE;
          end
        end
        default: st_q <= st_q;
      endcase
    end else if (sclFall && st_q == S_READ) begin
      oe_q <= !txByte_q[~cnt_q[2:0]];
    end
  end

  // internal cycle engine; holding the link off while busy keeps it simple
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // power-up restore of all channels starts at once
      busy_q     <= 1'b1;
      storing_q  <= 1'b0;
      opAll_q    <= 1'b1;
      opCh_q     <= 2'h0;
      storeVal_q <= 8'h00;
      opCnt_q    <= '0;
    end else if (opDone) begin
      busy_q    <= 1'b0;
      storing_q <= 1'b0;
      opCnt_q   <= '0;
    end else if (busy_q) begin
      opCnt_q <= opCnt_q + OP_W'(1);
    end else if (restoreGo || storeGo) begin
      busy_q     <= 1'b1;
      // pump runs for the whole save
      storing_q  <= storeGo;
      opAll_q    <= restoreGo && cmdCode == CMD_RESET_ALL;
      opCh_q     <= restoreGo ? qCh : tgtCh;
      storeVal_q <= storeCmdGo ? qWiper : sh_q;
    end
  end

  // nv_q is lost on rst here: rst stands for a first power-up
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // midscale first, restore follows when the engine finishes
      wiper_q <= {4{MIDSCALE}};
      nv_q    <= {4{NV_BLANK}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (opDone && !storing_q && (opAll_q || opCh_q == 2'(i))) begin
          wiper_q[i] <= nv_q[i];
        end else if (stepGo && (allCh || qCh == 2'(i))) begin
          wiper_q[i] <= stepOp(cmdCode, wiper_q[i]);
        end else if (wiperWrGo && regAddr_q[1:0] == 2'(i)) begin
          wiper_q[i] <= sh_q;
        end
        // erase at the start, program at the end
        if (storeGo && !busy_q && tgtCh == 2'(i)) begin
          nv_q[i] <= ERASED;
        end else if (opDone && storing_q && opCh_q == 2'(i)) begin
          nv_q[i] <= storeVal_q;
        end
      end
    end
  end

  // the pin is open drain: only ever pulled low
  assign sdaOut     = 1'b0;
  assign sdaOutEn   = oe_q;
  assign wiperPos   = wiper_q;
  assign chargePump = storing_q;
  assign nvBusy     = busy_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence addrByteDone;
    addrAck;
  endsequence

  mid_then_restore_a: assert property ($fell(rst) |-> wiper_q == {4{MIDSCALE}} && busy_q)
    else $error("wipers not midscale with restore pending");
  restore_length_a: assert property ($fell(busy_q) && !$past(storing_q) |->
    $past(opCnt_q) == RestoreLast)
    else $error("restore ended at wrong count");
  store_erase_a: assert property ($rose(storing_q) |-> nv_q[opCh_q] == ERASED)
    else $error("store did not erase first");
  pump_busy_a: assert property (storing_q |-> busy_q && opCnt_q <= StoreLast)
    else $error("pump on outside a save");
  halve_one_a: assert property (stepGo && cmdCode == CMD_HALVE_ONE |=>
    wiper_q[$past(qCh)] == ($past(qWiper) >> 1))
    else $error("halve result wrong");
  inc_saturate_a: assert property (stepGo && cmdCode == CMD_INC_ONE
    && qWiper == FULL_SCALE |=> wiper_q[$past(qCh)] == FULL_SCALE)
    else $error("increment wrapped");
  protect_block_a: assert property (instrAck && sh_q[INSTR_QUICK] && wpOn
    && cmdCode == CMD_INC_ALL |=> $stable(wiper_q))
    else $error("protected wiper changed");
  reserved_idle_a: assert property (instrAck && sh_q[INSTR_QUICK]
    && cmdCode[3:2] == CMD_RESERVED_TOP |=> $stable(wiper_q) && $stable(nv_q))
    else $error("reserved code changed state");
  busy_nack_a: assert property (addrByteDone and busy_q |=> !oe_q)
    else $error("address acked while busy");
  addr_match_a: assert property (addrByteDone and sh_q[7:1] != {ADDR_PREFIX, pinsAddr} |=> !oe_q)
    else $error("foreign address acked");
endmodule
`default_nettype wire

// [hw/quad_wiper_pkg.sv]
// constants and types for the quad wiper command control block
package quad_wiper_pkg;
  localparam logic [4:0] ADDR_PREFIX = 5'h0b;
  localparam logic [7:0] MIDSCALE    = 8'h80;
  localparam logic [7:0] FULL_SCALE  = 8'hff;
  localparam logic [7:0] ZERO_SCALE  = 8'h00;
  localparam logic [7:0] ERASED      = 8'hff;
  localparam logic [7:0] NV_BLANK    = 8'hff;
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned RESTORE_US  = 300;
  localparam int unsigned STORE_MS    = 26;
  localparam int unsigned RESTORE_CYC = RESTORE_US * CLK_MHZ;
  localparam int unsigned STORE_CYC   = STORE_MS * 1000 * CLK_MHZ;
  localparam int unsigned OP_W        = 21;
  // instruction byte fields
  localparam int unsigned INSTR_QUICK = 7;
  localparam int unsigned INSTR_NV    = 5;
  localparam int unsigned CMD_MSB     = 6;
  localparam int unsigned CMD_LSB     = 3;
  localparam int unsigned CH_MSB      = 2;
  // quick command codes
  localparam logic [3:0] CMD_NO_OPERATION = 4'h0;
  localparam logic [3:0] CMD_RESTORE      = 4'h1;
  localparam logic [3:0] CMD_STORE        = 4'h2;
  localparam logic [3:0] CMD_HALVE_ONE    = 4'h3;
  localparam logic [3:0] CMD_HALVE_ALL    = 4'h4;
  localparam logic [3:0] CMD_DEC_ONE      = 4'h5;
  localparam logic [3:0] CMD_DEC_ALL      = 4'h6;
  localparam logic [3:0] CMD_RESET_ALL    = 4'h7;
  localparam logic [3:0] CMD_DOUBLE_ONE   = 4'h8;
  localparam logic [3:0] CMD_DOUBLE_ALL   = 4'h9;
  localparam logic [3:0] CMD_INC_ONE      = 4'ha;
  localparam logic [3:0] CMD_INC_ALL      = 4'hb;
  localparam logic [1:0] CMD_RESERVED_TOP = 2'h3;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_INSTR, S_DATA, S_READ, S_IGNORE} linkState_t;
endpackage

// [test/i2c_host_model.sv]
// two-wire bus host that makes the link clock and drives data against a pull-up
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic clk_sys,
  input  wire logic sdaWire,
  output var  logic scl,
  output var  logic sdaDrive
);
  initial begin
    scl = 1'b1;
    sdaDrive = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // data moves mid low phase, sampled late in high phase
  task automatic bitx(input logic b, output logic s);
    tick(2);
    sdaDrive = b;
    tick(2);
    scl = 1'b1;
    tick(3);
    s = sdaWire;
    tick(1);
    scl = 1'b0;
  endtask
  task automatic start();
    sdaDrive = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  // clock parks high between frames
  task automatic stop();
    tick(2);
    sdaDrive = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sdaDrive = 1'b1;
    tick(4);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, s);
  endtask
  task automatic probe(input logic [6:0] a, output logic ack);
    start();
    send({a, 1'b0}, ack);
    stop();
  endtask
  task automatic poll(input logic [6:0] a, output int tries);
    logic ack;
    ack = 1'b0;
    tries = 0;
    while (ack !== 1'b1 && tries < 40) begin
      tries++;
      probe(a, ack);
    end
    // zero tries marks a poll that never got an ack
    if (ack !== 1'b1) tries = 0;
  endtask
  task automatic quick(input logic [6:0] a, input logic [3:0] c, input logic [2:0] ch,
                       output logic ack);
    logic a2;
    start();
    send({a, 1'b0}, ack);
    send({1'b1, c, ch}, a2);
    stop();
    ack = ack & a2;
  endtask
endmodule
`default_nettype wire

// [test/quad_wiper_command_control_test.sv]
// self-checking bench for the quad wiper command control block
`timescale 1ns/1ns
`default_nettype none
module quad_wiper_command_control_test;
  import quad_wiper_pkg::*;
  // short internal cycles keep the run brief but still outlast one address byte
  localparam int unsigned RestoreCyc = 200;
  localparam int unsigned StoreCyc   = 400;
  logic            clk_sys, rst, scl, sdaDrive, writeProtectN, addrSelectHi, addrSelectLo;
  wire logic       sdaOut, sdaOutEn, chargePump, nvBusy, sdaWire;
  wire logic [3:0][7:0] wiperPos;
  logic [6:0]      addr;
  logic [7:0]      w[4], nv[4], d;
  logic [31:0]     seed, r;
  logic [3:0]      c;
  logic [2:0]      ch;
  logic            ok;
  int              tries, miscompares, compares;
  assign sdaWire = (sdaOutEn ? sdaOut : 1'b1) & sdaDrive;
  assign addr = {ADDR_PREFIX, addrSelectHi, addrSelectLo};
  quad_wiper_command_control #(
    .RestoreCycles(RestoreCyc),
    .StoreCycles  (StoreCyc)
  ) dut_u (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .scl          (scl),
    .sdaIn        (sdaWire),
    .writeProtectN(writeProtectN),
    .addrSelectHi (addrSelectHi),
    .addrSelectLo (addrSelectLo),
    .sdaOut       (sdaOut),
    .sdaOutEn     (sdaOutEn),
    .wiperPos     (wiperPos),
    .chargePump   (chargePump),
    .nvBusy       (nvBusy)
  );
  i2c_host_model host_u (
    .clk_sys (clk_sys),
    .sdaWire (sdaWire),
    .scl     (scl),
    .sdaDrive(sdaDrive)
  );
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected wiper after a quick command; channel bit 2 set selects none for single-channel codes
  function automatic logic [7:0] nxt(input logic [3:0] k, input logic [2:0] s, input int i);
    logic [7:0] v;
    v = w[i];
    if (!writeProtectN && !(k inside {4'h1, 4'h7})) return v;
    if (!(k inside {4'h4, 4'h6, 4'h7, 4'h9, 4'hb}) &&
        !(s == 3'(i) && k inside {4'h1, 4'h3, 4'h5, 4'h8, 4'ha})) return v;
    case (k)
      4'h1, 4'h7: return nv[i];
      4'h3, 4'h4: return v >> 1;
      4'h5, 4'h6: return (v == ZERO_SCALE) ? v : v - 8'h01;
      4'h8, 4'h9: return (v == ZERO_SCALE) ? 8'h01 : (v[7] ? FULL_SCALE : v << 1);
      default: return (v == FULL_SCALE) ? v : v + 8'h01;
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkAll();
    for (int i = 0; i < 4; i++) check("wiper", w[i], wiperPos[i]);
  endtask
  task automatic regWr(input logic nvw, input logic [1:0] s, input logic [7:0] v);
    logic a1, a2, a3;
    host_u.start();
    host_u.send({addr, 1'b0}, a1);
    host_u.send({2'b00, nvw, 3'h0, s}, a2);
    host_u.send(v, a3);
    host_u.stop();
    if (writeProtectN && nvw) nv[s] = v;
    else if (writeProtectN) w[s] = v;
    check("write ack", 8'h01, {7'h00, a1 & a2 & a3});
    check("pump", {7'h00, nvw && writeProtectN}, {7'h00, chargePump});
    host_u.poll(addr, tries);
    check("poll ack", 8'h01, {7'h00, tries > 0});
    chkAll();
  endtask
  task automatic doCmd(input logic [3:0] k, input logic [2:0] s);
    logic [7:0] e[4];
    logic       bz;
    bz = k inside {4'h1, 4'h7} || (k == 4'h2 && writeProtectN);
    for (int i = 0; i < 4; i++) e[i] = nxt(k, s, i);
    if (k == 4'h2 && writeProtectN) nv[s[1:0]] = w[s[1:0]];
    host_u.quick(addr, k, s, ok);
    check("quick ack", 8'h01, {7'h00, ok});
    check("pump", {7'h00, k == 4'h2 && writeProtectN}, {7'h00, chargePump});
    check("busy", {7'h00, bz}, {7'h00, nvBusy});
    host_u.poll(addr, tries);
    check("poll ack", 8'h01, {7'h00, tries > 0});
    check("busy nack", {7'h00, bz}, {7'h00, tries > 1});
    w = e;
    chkAll();
  endtask
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    miscompares++;
    end_of_test();
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    seed = 32'd2736;
    miscompares = 0;
    compares = 0;
    writeProtectN = 1'b0;
    r = rnd();
    {addrSelectHi, addrSelectLo} = r[1:0];
    for (int i = 0; i < 4; i++) begin
      w[i] = MIDSCALE;
      nv[i] = NV_BLANK;
    end
    repeat (8) @(posedge clk_sys);
    #2;
    chkAll();
    check("reset busy", 8'h01, {7'h00, nvBusy});
    rst = 1'b0;
    host_u.poll(addr, tries);
    check("startup nack", 8'h01, {7'h00, tries > 1});
    w = nv;
    chkAll();
    for (int p = 0; p < 10; p++) begin
      if (p == 5) {addrSelectHi, addrSelectLo} = ~addr[1:0];
      host_u.probe({(p % 5 == 4) ? 5'h0a : ADDR_PREFIX, 2'(p % 5)}, ok);
      check("addr ack", {7'h00, p % 5 < 4 && 2'(p % 5) == addr[1:0]}, {7'h00, ok});
    end
    writeProtectN = 1'b1;
    for (int i = 0; i < 4; i++) regWr(1'b0, 2'(i), 8'(rnd()));
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      c = (n < 16) ? 4'(n) : r[3:0];
      ch = r[6:4];
      if (c == 4'h1 || c == 4'h2) ch[2] = 1'b0;
      doCmd(c, ch);
      // no_operation follows each single-channel restore
      if (c == 4'h1) doCmd(4'h0, ch);
    end
    regWr(1'b0, 2'd0, ZERO_SCALE);
    for (int n = 0; n < 9; n++) doCmd(4'h8, 3'd0);
    check("double limit", FULL_SCALE, wiperPos[0]);
    doCmd(4'ha, 3'd0);
    for (int n = 0; n < 8; n++) doCmd(4'h3, 3'd0);
    check("halve limit", ZERO_SCALE, wiperPos[0]);
    doCmd(4'h5, 3'd0);
    doCmd(4'h2, 3'd1);
    regWr(1'b0, 2'd1, ~w[1]);
    regWr(1'b1, 2'd3, 8'(rnd()));
    doCmd(4'h7, 3'd0);
    writeProtectN = 1'b0;
    regWr(1'b0, 2'd2, ~w[2]);
    regWr(1'b1, 2'd0, ~nv[0]);
    doCmd(4'hb, 3'd0);
    doCmd(4'h2, 3'd2);
    host_u.start();
    host_u.send({addr, 1'b1}, ok);
    host_u.recv(1'b0, d);
    check("read 0", w[0], d);
    host_u.recv(1'b1, d);
    check("read 1", w[1], d);
    host_u.stop();
    doCmd(4'h7, 3'd0);
    end_of_test();
  end
endmodule
`default_nettype wire
